// File: logic/camera_pixel_lane_mapper.sv
`timescale 1ns/100ps
// How it works
// [RULE1] The generated pixel clock is driven out as the serializer clock input in every mode.
// [RULE2] All lanes change only on the MCLK edge at which the pixel clock falls.
// [RULE3] The pixel clock rate follows the active output mode.
// [RULE4] The frame qualifier lane is high exactly while a frame is being sent.
// [RULE5] The line qualifier lane is high exactly while a line of a frame is being sent.
// [RULE6] Pixel lanes carry data only when both qualifiers are high, and the receiver ignores them otherwise.
// [RULE7] Line qualifier sits on lane 24, frame qualifier on lane 25, and lane 26 is reserved.
// [RULE8] Single modes map bits 0-4 to lanes 0-4, bit 7 to 5, bit 5 to 6, bit 6 to 27, and in 10-bit bits 8, 9 to lanes 7, 8.
// [RULE9] Dual 10-bit puts the odd pixel on the single map and the even pixel on lanes 13 to 22.
// [RULE10] Dual 8-bit puts the odd pixel on the single map and the even pixel on lanes 7 to 14.
// [RULE11] The receiver reads each output lane as the matching input lane and picks its own sampling edge.
// [RULE12] The pixel clock is 42 MHz in single modes and 21 MHz in dual modes.
// [RULE13] The 8-bit modes send only the upper eight bits of each 10-bit pixel.
// [RULE14] With no valid data both qualifiers stay low on every pixel clock cycle.
// [RULE15] Reserved lanes are always driven low.
// [RULE16] A new output mode is taken only while the frame qualifier is low.
module camera_pixel_lane_mapper
(
  input  wire logic                                 MCLK,
  input  wire logic                                 SYS_RST,
  input  wire logic [1:0]                           MODE_SELECT,
  input  wire logic                                 FRAME_ACTIVE,
  input  wire logic                                 LINE_ACTIVE,
  input  wire logic [pixel_lane_pkg::PIX_BITS-1:0]  PIXEL_ODD,
  input  wire logic [pixel_lane_pkg::PIX_BITS-1:0]  PIXEL_EVEN,
  output logic [pixel_lane_pkg::LANE_COUNT-1:0]     SERIALIZER_INPUT_LANE,
  output logic                                      SERIALIZER_CLOCK_INPUT,
  output logic                                      PIXEL_TAKE,
  output logic [1:0]                                MODE_ACTIVE
);
  import pixel_lane_pkg::*;

  mode_t                 mode_q;
  mode_t                 mode_d;
  logic [ACC_BITS-1:0]   phase_step;
  logic                  pclk;
  logic                  fall_next;
  logic [LANE_COUNT-1:0] lane_q;
  logic [LANE_COUNT-1:0] lane_d;
  logic                  take_q;
  logic                  take_d;
  logic                  eight_bit;
  logic [PIX_BITS-1:0]   odd_val;
  logic [PIX_BITS-1:0]   even_val;
  logic                  nco_restart;

  // Rate depends on mode; switching only between frames keeps frames clean
  always_comb
  begin
    if (mode_q == MODE_DUAL10 || mode_q == MODE_DUAL8)  // [RULE3]
      phase_step = STEP_DUAL[ACC_BITS-1:0];             // [RULE12]
    else
      phase_step = STEP_SINGLE[ACC_BITS-1:0];           // [RULE12]
  end

  // A mode change restarts the phase so the first period in the new mode is
  // whole; a carried-over phase could make it up to two MCLK too short
  assign nco_restart = SYS_RST | (mode_d != mode_q);  // [RULE3] [RULE12]

  pixel_clock_nco u_nco
  (
    .clk        (MCLK),
    .rst        (nco_restart),
    .phase_step (phase_step),
    .clk_out    (pclk),
    .fall_next  (fall_next)
  );

  // Mode latch: taken at a pixel clock fall while no frame is on the link
  always_comb
  begin
    mode_d = mode_q;
    if (fall_next && !lane_q[LANE_FRAME] && !FRAME_ACTIVE)  // [RULE16]
      mode_d = mode_t'(MODE_SELECT);
  end

  // Source pixels as 10-bit values; 8-bit modes keep only the upper byte
  always_comb
  begin
    eight_bit = (mode_q == MODE_SINGLE8) || (mode_q == MODE_DUAL8);
    if (eight_bit)
    begin
      odd_val  = {{PIX8_SHIFT{1'b0}}, PIXEL_ODD[PIX_BITS-1:PIX8_SHIFT]};   // [RULE13]
      even_val = {{PIX8_SHIFT{1'b0}}, PIXEL_EVEN[PIX_BITS-1:PIX8_SHIFT]};  // [RULE13]
    end
    else
    begin
      odd_val  = PIXEL_ODD;
      even_val = PIXEL_EVEN;
    end
  end

  // Lane map, evaluated once per pixel clock so lanes move with its fall
  always_comb
  begin
    lane_d = lane_q;
    take_d = 1'b0;
    if (fall_next)  // [RULE2]
    begin
      take_d = 1'b1;
      lane_d = '0;  // Reserved lanes and idle pixel lanes stay low [RULE15]
      lane_d[LANE_FRAME] = FRAME_ACTIVE;                 // [RULE4] [RULE7] [RULE14]
      lane_d[LANE_LINE]  = FRAME_ACTIVE & LINE_ACTIVE;   // [RULE5] [RULE7] [RULE14]
      if (FRAME_ACTIVE && LINE_ACTIVE)                   // [RULE6]
      begin
        for (int b = 0; b < PIX_BITS; b++)
        begin
          if (!eight_bit || b < PIX8_BITS)
            lane_d[SINGLE_LANE[b]] = odd_val[b];         // [RULE8]
        end
        if (mode_q == MODE_DUAL10)
        begin
          for (int b = 0; b < PIX_BITS; b++)
            lane_d[DUAL10_EVEN_LANE[b]] = even_val[b];   // [RULE9]
        end
        else if (mode_q == MODE_DUAL8)
        begin
          for (int b = 0; b < PIX8_BITS; b++)
            lane_d[DUAL8_EVEN_LANE[b]] = even_val[b];    // [RULE10]
        end
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      mode_q <= mode_t'(MODE_RESET);
      lane_q <= '0;
      take_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      lane_q <= lane_d;
      take_q <= take_d;
    end
  end

  // Lanes and the serializer clock come from flops updated on one edge
  assign SERIALIZER_INPUT_LANE  = lane_q;
  assign SERIALIZER_CLOCK_INPUT = pclk;      // [RULE1]
  assign PIXEL_TAKE             = take_q;
  assign MODE_ACTIVE            = mode_q;

  // Helper: MCLK cycles since the last pixel clock fall; it saturates so a
  // stalled clock can never wrap back into a legal count
  logic [7:0] gap_q;
  logic [7:0] gap_d;
  logic       seen_q;
  logic       seen_d;

  always_comb
  begin
    gap_d  = gap_q;
    seen_d = seen_q;
    if (fall_next)
    begin
      gap_d  = 8'h01;
      seen_d = 1'b1;
    end
    else if (gap_q != 8'hFF)
    begin
      gap_d = gap_q + 8'h01;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      gap_q  <= 8'h00;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  lanes_on_fall_a: assert property ( // [RULE2]
    $changed(lane_q) |-> $fell(SERIALIZER_CLOCK_INPUT))
    else $error("Lanes changed away from a pixel clock fall");

  single_rate_a: assert property ( // [RULE3] [RULE12]
    (fall_next && seen_q && mode_q == MODE_SINGLE10 && $stable(mode_q))
      |-> (gap_q >= SINGLE_MIN_CYC && gap_q <= SINGLE_MAX_CYC))
    else $error("Single mode pixel clock period wrong");

  dual_rate_a: assert property ( // [RULE3] [RULE12]
    (fall_next && seen_q && mode_q == MODE_DUAL8 && $stable(mode_q))
      |-> (gap_q >= DUAL_MIN_CYC && gap_q <= DUAL_MAX_CYC))
    else $error("Dual mode pixel clock period wrong");

  frame_follows_a: assert property ( // [RULE4]
    $fell(SERIALIZER_CLOCK_INPUT) |-> lane_q[LANE_FRAME] == $past(FRAME_ACTIVE))
    else $error("Frame qualifier does not follow frame activity");

  line_follows_a: assert property ( // [RULE5]
    $fell(SERIALIZER_CLOCK_INPUT)
      |-> lane_q[LANE_LINE] == ($past(FRAME_ACTIVE) && $past(LINE_ACTIVE)))
    else $error("Line qualifier does not follow line activity");

  idle_pixels_low_a: assert property ( // [RULE6] [RULE14]
    !(lane_q[LANE_LINE] && lane_q[LANE_FRAME])
      |-> (lane_q & ~(28'h1 << LANE_FRAME)) == 28'h0)
    else $error("Pixel lanes active outside a valid line");

  reserved_low_a: assert property ( // [RULE7] [RULE15]
    !lane_q[LANE_RSVD] && (mode_q != MODE_DUAL8 || lane_q[23:15] == 9'h000))
    else $error("Reserved lane driven high");

  single_msb_a: assert property ( // [RULE8]
    ($fell(SERIALIZER_CLOCK_INPUT) && lane_q[LANE_LINE] && mode_q == MODE_SINGLE10
      && $stable(mode_q))
      |-> lane_q[8] == $past(PIXEL_ODD[9]) && lane_q[27] == $past(PIXEL_ODD[6]))
    else $error("Single 10-bit lane map wrong");

  dual10_even_a: assert property ( // [RULE9]
    ($fell(SERIALIZER_CLOCK_INPUT) && lane_q[LANE_LINE] && mode_q == MODE_DUAL10
      && $stable(mode_q))
      |-> lane_q[14] == $past(PIXEL_EVEN[9]) && lane_q[15] == $past(PIXEL_EVEN[0]))
    else $error("Dual 10-bit even pixel map wrong");

  dual8_even_a: assert property ( // [RULE10] [RULE13]
    ($fell(SERIALIZER_CLOCK_INPUT) && lane_q[LANE_LINE] && mode_q == MODE_DUAL8
      && $stable(mode_q))
      |-> lane_q[7] == $past(PIXEL_EVEN[2]) && lane_q[11] == $past(PIXEL_EVEN[9]))
    else $error("Dual 8-bit even pixel map wrong");

  mode_between_frames_a: assert property ( // [RULE16]
    $changed(mode_q) |-> !lane_q[LANE_FRAME] && !$past(lane_q[LANE_FRAME]))
    else $error("Output mode changed inside a frame");

  mode_taken_a: assert property ( // [RULE16]
    (fall_next && !lane_q[LANE_FRAME] && !FRAME_ACTIVE) |=> mode_q == $past(MODE_SELECT))
    else $error("Output mode request not taken between frames");

  // Sample strobe, qualifier nesting and the remaining rate and map checks
  take_on_fall_a: assert property ( // [RULE2]
    PIXEL_TAKE == $fell(SERIALIZER_CLOCK_INPUT))
    else $error("Sample pulse not aligned with a pixel clock fall");

  line_in_frame_a: assert property ( // [RULE5] [RULE14]
    lane_q[LANE_LINE] |-> lane_q[LANE_FRAME])
    else $error("Line qualifier high outside a frame");

  single8_rate_a: assert property ( // [RULE3] [RULE12]
    (fall_next && seen_q && mode_q == MODE_SINGLE8 && $stable(mode_q))
      |-> (gap_q >= SINGLE_MIN_CYC && gap_q <= SINGLE_MAX_CYC))
    else $error("Single 8-bit pixel clock period wrong");

  dual10_rate_a: assert property ( // [RULE3] [RULE12]
    (fall_next && seen_q && mode_q == MODE_DUAL10 && $stable(mode_q))
      |-> (gap_q >= DUAL_MIN_CYC && gap_q <= DUAL_MAX_CYC))
    else $error("Dual 10-bit pixel clock period wrong");

  single10_low_a: assert property ( // [RULE8]
    ($fell(SERIALIZER_CLOCK_INPUT) && lane_q[LANE_LINE] && mode_q == MODE_SINGLE10
      && $stable(mode_q))
      |-> lane_q[4:0] == $past(PIXEL_ODD[4:0]) && lane_q[5] == $past(PIXEL_ODD[7]))
    else $error("Single 10-bit low bits lane map wrong");

  single8_map_a: assert property ( // [RULE13]
    ($fell(SERIALIZER_CLOCK_INPUT) && lane_q[LANE_LINE] && mode_q == MODE_SINGLE8
      && $stable(mode_q))
      |-> lane_q[5] == $past(PIXEL_ODD[9]) && lane_q[0] == $past(PIXEL_ODD[2]))
    else $error("Single 8-bit lane map wrong");

  dual10_odd_a: assert property ( // [RULE9]
    ($fell(SERIALIZER_CLOCK_INPUT) && lane_q[LANE_LINE] && mode_q == MODE_DUAL10
      && $stable(mode_q))
      |-> lane_q[8] == $past(PIXEL_ODD[9]) && lane_q[16] == $past(PIXEL_EVEN[6]))
    else $error("Dual 10-bit odd pixel map wrong");

  dual8_odd_a: assert property ( // [RULE10] [RULE13]
    ($fell(SERIALIZER_CLOCK_INPUT) && lane_q[LANE_LINE] && mode_q == MODE_DUAL8
      && $stable(mode_q))
      |-> lane_q[5] == $past(PIXEL_ODD[9]) && lane_q[14] == $past(PIXEL_EVEN[7]))
    else $error("Dual 8-bit odd pixel map wrong");

  single_reserved_a: assert property ( // [RULE8] [RULE15]
    (mode_q == MODE_SINGLE10 || mode_q == MODE_SINGLE8) |-> lane_q[23:9] == 15'h0000)
    else $error("Reserved lane active in a single mode");

  eight_bit_reserved_a: assert property ( // [RULE13] [RULE15]
    mode_q == MODE_SINGLE8 |-> lane_q[8:7] == 2'h0)
    else $error("Upper lanes active in single 8-bit mode");

  dual10_reserved_a: assert property ( // [RULE9] [RULE15]
    mode_q == MODE_DUAL10 |-> lane_q[12:9] == 4'h0 && !lane_q[23])
    else $error("Reserved lane active in dual 10-bit mode");

  // Main scenarios: line start, frame end, dual entry, held request, dual 8-bit data
  line_start_c: cover property ($rose(lane_q[LANE_LINE]));
  frame_end_c: cover property ($fell(lane_q[LANE_FRAME]));
  dual_mode_c: cover property ($changed(mode_q) ##1 mode_q == MODE_DUAL10);
  mode_refused_c: cover property (fall_next && FRAME_ACTIVE && MODE_SELECT != mode_q);
  dual8_data_c: cover property (
    $fell(SERIALIZER_CLOCK_INPUT) && lane_q[LANE_LINE] && mode_q == MODE_DUAL8);

endmodule // camera_pixel_lane_mapper

// File: shared/pixel_lane_pkg.sv
package pixel_lane_pkg;

  // Output modes in the order of the two-bit mode select code
  typedef enum logic [1:0] {
    MODE_SINGLE10,
    MODE_SINGLE8,
    MODE_DUAL10,
    MODE_DUAL8
  } mode_t;

  localparam int LANE_COUNT = 28;
  localparam int PIX_BITS   = 10;
  localparam int PIX8_BITS  = 8;
  localparam int PIX8_SHIFT = 2;   // 8-bit modes drop the two LSBs

  // Fixed qualifier and reserved lanes
  localparam int LANE_LINE  = 24;
  localparam int LANE_FRAME = 25;
  localparam int LANE_RSVD  = 26;

  // Lane for each pixel bit, index is the bit number
  localparam int SINGLE_LANE [PIX_BITS] = '{0, 1, 2, 3, 4, 6, 27, 5, 7, 8};
  localparam int DUAL10_EVEN_LANE [PIX_BITS] = '{15, 18, 19, 20, 21, 22, 16, 17, 13, 14};
  localparam int DUAL8_EVEN_LANE [PIX8_BITS] = '{7, 8, 9, 12, 13, 14, 10, 11};

  // Clock rates
  localparam longint MCLK_HZ        = 250_000_000;
  localparam longint PCLK_SINGLE_HZ = 42_000_000;
  localparam longint PCLK_DUAL_HZ   = 21_000_000;

  // Phase steps of the 32-bit accumulator: f_out * 2^32 / f_mclk
  localparam int     ACC_BITS    = 32;
  localparam longint STEP_SINGLE = (PCLK_SINGLE_HZ << ACC_BITS) / MCLK_HZ;
  localparam longint STEP_DUAL   = (PCLK_DUAL_HZ << ACC_BITS) / MCLK_HZ;

  // Fall-to-fall spacing in MCLK cycles: floor and ceiling of the ratio
  localparam int SINGLE_MIN_CYC = int'(MCLK_HZ / PCLK_SINGLE_HZ);
  localparam int SINGLE_MAX_CYC = SINGLE_MIN_CYC + 1;
  localparam int DUAL_MIN_CYC   = int'(MCLK_HZ / PCLK_DUAL_HZ);
  localparam int DUAL_MAX_CYC   = DUAL_MIN_CYC + 1;

  localparam logic [1:0] MODE_RESET = 2'h0;

endpackage

// File: logic/pixel_clock_nco.sv
`timescale 1ns/100ps
module pixel_clock_nco
  import pixel_lane_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [ACC_BITS-1:0] phase_step,
  output logic                     clk_out,
  output logic                     fall_next
);

  logic [ACC_BITS-1:0] acc_q;
  logic [ACC_BITS-1:0] acc_d;
  logic                clk_q;
  logic                clk_d;

  // Phase accumulator; its top bit is the generated clock. A fractional
  // step gives the mean rate to within the truncation of the step, at the cost of one MCLK of jitter.
  always_comb
  begin
    acc_d     = acc_q + phase_step;
    clk_d     = acc_d[ACC_BITS-1];
    fall_next = acc_q[ACC_BITS-1] & ~acc_d[ACC_BITS-1]; // Falls at the next edge
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_q <= '0;
      clk_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      clk_q <= clk_d;
    end
  end

  assign clk_out = clk_q;

endmodule // pixel_clock_nco

// File: tb/pixel_grabber_model.sv
`timescale 1ns/100ps
module pixel_grabber_model
(
  input  wire logic        clk,
  input  wire logic [27:0] lanes,
  input  wire logic        pix_clk,
  output logic [27:0]      rx_lane,
  output logic [9:0]       rx_pix
);
  logic pclk_q = 1'b0;

  // Latch the word one MCLK after each pixel clock fall; a real receiver may pick either edge
  always @(posedge clk)
  begin
    pclk_q <= pix_clk;
    if (pclk_q && !pix_clk)
    begin
      rx_lane <= lanes;
      if (lanes[24] && lanes[25])
        rx_pix <= {lanes[8:7], lanes[5], lanes[27], lanes[6], lanes[4:0]};
    end
  end
endmodule  // pixel_grabber_model

// File: tb/camera_pixel_lane_mapper_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("Error %s expected %h seen %h", n, e, g); err_total++; end end
module camera_pixel_lane_mapper_tb;
  import pixel_lane_pkg::*;
  logic        MCLK = 0, SYS_RST = 1, FRAME_ACTIVE = 0, LINE_ACTIVE = 0;
  logic [1:0]  MODE_SELECT = 0, MODE_ACTIVE, exp_mode = 0;
  logic [9:0]  PIXEL_ODD = 0, PIXEL_EVEN = 0, rx_pix;
  logic [27:0] SERIALIZER_INPUT_LANE, rx_lane;
  logic        SERIALIZER_CLOCK_INPUT, PIXEL_TAKE;
  int          err_total = 0, samples_checked = 0, cyc = 0, take_at = 0, per = 0;

  camera_pixel_lane_mapper dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .MODE_SELECT(MODE_SELECT),
    .FRAME_ACTIVE(FRAME_ACTIVE), .LINE_ACTIVE(LINE_ACTIVE), .PIXEL_ODD(PIXEL_ODD),
    .PIXEL_EVEN(PIXEL_EVEN), .SERIALIZER_INPUT_LANE(SERIALIZER_INPUT_LANE),
    .SERIALIZER_CLOCK_INPUT(SERIALIZER_CLOCK_INPUT), .PIXEL_TAKE(PIXEL_TAKE),
    .MODE_ACTIVE(MODE_ACTIVE));
  pixel_grabber_model grabber (.clk(MCLK), .lanes(SERIALIZER_INPUT_LANE),
    .pix_clk(SERIALIZER_CLOCK_INPUT), .rx_lane(rx_lane), .rx_pix(rx_pix));

  always #2 MCLK = ~MCLK;

  // Cycle count doubles as the hang guard
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  // Expected word; mode bit 0 selects 8-bit, bit 1 dual
  function automatic logic [27:0] exp_lanes(logic [1:0] m, logic f, l, logic [9:0] o, e);
    logic [9:0]  p;
    logic [9:0]  q;
    logic [27:0] v;
    p = m[0] ? {2'h0, o[9:2]} : o;
    q = m[0] ? {2'h0, e[9:2]} : e;
    v = '0;
    if (f && l)
    begin
      v[4:0] = p[4:0];
      v[5] = p[7];
      v[6] = p[5];
      v[27] = p[6];
      if (!m[0])
        v[8:7] = p[9:8];
      if (m == 2'h2)
        v[22:13] = {q[5:1], q[7:6], q[0], q[9:8]};
      if (m == 2'h3)
        v[14:7] = {q[5:3], q[7:6], q[2:0]};
    end
    v[24] = f & l;
    v[25] = f;
    return v;
  endfunction

  // Lanes may only move at the MCLK edge that raises PIXEL_TAKE
  task automatic wait_take();
    int          n;
    logic [27:0] held;
    n = 0;
    held = SERIALIZER_INPUT_LANE;
    do
    begin
      @(posedge MCLK);
      #1;
      n++;
      if (PIXEL_TAKE !== 1'b1)
        `CHK("lanes_hold", held, SERIALIZER_INPUT_LANE)
    end
    while (PIXEL_TAKE !== 1'b1 && n < 40);
    `CHK("take_seen", 1'b1, PIXEL_TAKE)
    `CHK("clk_falls", 1'b0, SERIALIZER_CLOCK_INPUT)
    per = cyc - take_at;
    take_at = cyc;
  endtask

  // One pixel clock: present inputs, check the word and the grabber's copy
  task automatic step(input logic f, l, input logic [9:0] o, e);
    @(negedge MCLK);
    FRAME_ACTIVE = f;
    LINE_ACTIVE = l;
    PIXEL_ODD = o;
    PIXEL_EVEN = e;
    wait_take();
    `CHK("lanes", exp_lanes(exp_mode, f, l, o, e), SERIALIZER_INPUT_LANE)
    @(posedge MCLK);
    #1;
    `CHK("rx_lanes", SERIALIZER_INPUT_LANE, rx_lane)
    if (exp_mode == 2'h0 && f && l)
      `CHK("rx_pix", o, rx_pix)
    else if (exp_mode == 2'h1 && f && l)
      `CHK("rx_pix8", o >> 2, rx_pix)
  endtask

  // Two idle clocks let a new mode land with the frame qualifier low
  task automatic set_mode(input logic [1:0] m);
    @(negedge MCLK);
    MODE_SELECT = m;
    step(0, 0, 10'h000, 10'h000);
    step(0, 0, 10'h000, 10'h000);
    exp_mode = m;
    `CHK("mode", exp_mode, MODE_ACTIVE)
  endtask

  task automatic do_reset();
    @(negedge MCLK);
    SYS_RST = 1;
    MODE_SELECT = 0;
    repeat (4) @(posedge MCLK);
    #1;
    `CHK("rst_lanes", 28'h0000000, SERIALIZER_INPUT_LANE)
    `CHK("rst_state", 4'h0, {SERIALIZER_CLOCK_INPUT, PIXEL_TAKE, MODE_ACTIVE})
    @(negedge MCLK);
    SYS_RST = 0;
    exp_mode = 0;
    wait_take();
  endtask

  // Walk one bit through both pixels in every mode, and check the clock spacing
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      set_mode(m[1:0]);
      for (int b = 0; b < 10; b++)
      begin
        step(1, 1, 10'h001 << b, 10'h200 >> b);
        `CHK("period", 1'b1, exp_mode[1] ? per inside {[11:12]} : per inside {[5:6]})
      end
    end
  endtask

  // Qualifier combinations gate the pixel lanes
  task automatic t_qual();
    step(1, 0, 10'h3FF, 10'h3FF);
    step(0, 1, 10'h3FF, 10'h3FF);
    step(1, 1, 10'h3FF, 10'h3FF);
  endtask

  // A mode request inside a frame waits for the frame to end
  task automatic t_hold();
    step(1, 1, 10'h2B5, 10'h14A);
    @(negedge MCLK);
    MODE_SELECT = 2'h1;
    step(1, 1, 10'h155, 10'h2AA);
    step(1, 1, 10'h0F0, 10'h30F);
    `CHK("mode_held", exp_mode, MODE_ACTIVE)
    set_mode(2'h1);
    step(1, 1, 10'h2B5, 10'h14A);
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    do_reset();
    t_modes();
    t_qual();
    t_hold();
    do_reset();
    step(1, 1, 10'h3C3, 10'h000);
    report_and_stop();
  end
endmodule  // camera_pixel_lane_mapper_tb
